//--- core/priority_arbiter_pkg.sv
// constants, register map and field layout of the interrupt priority controller
// assumes one 250 MHz peripheral clock and an APB master with 32-bit data
// Function
// - levels zero to sixteen, zero masks the cause
// - nonmaskable is level sixteen unless blocked
// - sleep or standby accepts nonmaskable despite block
// - nonmaskable pin edge detected, polarity selectable
// - polarity change clears flag, blinds twenty cycles
// - nonmaskable exception leaves mask level untouched
// - control register shows live nonmaskable pin level
// - control resets to 8000 or 0000 per pin
// - every reset clears control and priority registers
// - each peripheral source gets programmable priority level
// - notify output flags pending interrupt or refresh
// - encoded level requests obey cpu mask level
// - three sixteen-bit read-write registers
// - encoded inputs are inverted, all ones idle
// - level inputs accepted after two stable samples
// - unique event code per accepted cause
package priority_arbiter_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;
	localparam int LVL_W = 5;
	localparam int CODE_W = 12;
	localparam int N_PERIPH = 8;
	localparam int PRIO_W = 4;
	localparam int ST_W = 3;

	// printed offsets are register indices; byte address is four times the index
	localparam logic [31:0] CTRL_IDX = 32'hfffffee0;
	localparam logic [31:0] PRIO_A_IDX = 32'hfffffee2;
	localparam logic [31:0] PRIO_B_IDX = 32'hfffffee4;

	function automatic logic [ADDR_W-1:0] reg_byte_addr(input logic [31:0] idx);
		reg_byte_addr = {idx[ADDR_W-3:0], 2'b00};
	endfunction

	localparam logic [ADDR_W-1:0] CTRL_ADDR = reg_byte_addr(CTRL_IDX);
	localparam logic [ADDR_W-1:0] PRIO_A_ADDR = reg_byte_addr(PRIO_A_IDX);
	localparam logic [ADDR_W-1:0] PRIO_B_ADDR = reg_byte_addr(PRIO_B_IDX);
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h000;
	localparam logic [ADDR_W-1:0] MASK_ADDR = 12'h004;
	localparam logic [ADDR_W-1:0] EVENT_ADDR = 12'h008;

	localparam int CTRL_LEVEL_BIT = 15;
	localparam int CTRL_EDGE_BIT = 8;
	localparam logic [REG_W-1:0] PRIO_RESET = 16'h0000;
	localparam logic EDGE_RESET = 1'b0;

	localparam int ST_NMI = 0;
	localparam int ST_IRL = 1;
	localparam int ST_ACCEPT = 2;

	localparam logic [LVL_W-1:0] NMI_LEVEL = 5'h10;
	localparam logic [PRIO_W-1:0] IRL_IDLE = 4'hf;
	localparam logic [CODE_W-1:0] EVT_NMI = 12'h1c0;
	localparam logic [CODE_W-1:0] EVT_IRL_BASE = 12'h200;
	localparam logic [CODE_W-1:0] EVT_PERIPH_BASE = 12'h400;
	localparam logic [CODE_W-1:0] EVT_STEP = 12'h020;

	localparam int NMI_BLANK_CYCLES = 20;
	localparam logic [4:0] NMI_BLANK_CNT = 5'(NMI_BLANK_CYCLES);
	localparam logic [1:0] PRIME_CNT = 2'h3;

	typedef enum logic [1:0] {
		STARTUP_PRIME = 2'b01,
		STARTUP_RUN = 2'b10
	} startup_type;
endpackage

//--- core/pin_filter.sv
// three-stage input filter for asynchronous pins
// assumes pins may change at any time relative to pclk
module pin_filter
	import priority_arbiter_pkg::*;
#(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] level_out
);
	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;
	logic [WIDTH-1:0] stage3_ff;
	logic [WIDTH-1:0] level_ff;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stage1_ff <= RESET_VAL;
			stage2_ff <= RESET_VAL;
			stage3_ff <= RESET_VAL;
		end
		else
		begin
			stage1_ff <= pin_in;
			stage2_ff <= stage1_ff;
			stage3_ff <= stage2_ff;
		end
	end

	// a new value is taken only once two consecutive samples agree
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			level_ff <= RESET_VAL;
		else if (stage2_ff == stage3_ff)
			level_ff <= stage3_ff;
	end

	assign level_out = level_ff;
endmodule

//--- core/interrupt_priority_ctrl.sv
// interrupt priority controller: nonmaskable edge, encoded levels, peripheral sources
// assumes APB master on pclk, cpu handshake signals synchronous to pclk
module interrupt_priority_ctrl
	import priority_arbiter_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic nmi_pin,
	input wire logic [PRIO_W-1:0] encoded_level_inputs,
	input wire logic [N_PERIPH-1:0] periph_req,
	input wire logic refresh_req,
	input wire logic cpu_block_bit,
	input wire logic [PRIO_W-1:0] cpu_mask_level,
	input wire logic low_power_mode,
	input wire logic cpu_accept,
	output logic cpu_irq_req,
	output logic [LVL_W-1:0] cpu_irq_level,
	output logic [CODE_W-1:0] event_code_register,
	output logic cpu_mask_load,
	output logic pending_notify_out,
	output logic irq_out
);
	function automatic logic [CODE_W-1:0] evt_code(input logic [CODE_W-1:0] base,
		input logic [PRIO_W-1:0] idx);
		evt_code = CODE_W'(base + CODE_W'(idx) * EVT_STEP);
	endfunction

	logic nmi_level;
	logic [PRIO_W-1:0] irl_code;
	startup_type startup_ff;
	logic [1:0] prime_cnt_ff;
	logic running;
	logic edge_sel_ff;
	logic [REG_W-1:0] prio_a_ff;
	logic [REG_W-1:0] prio_b_ff;
	logic [ST_W-1:0] status_ff;
	logic [ST_W-1:0] mask_ff;
	logic [CODE_W-1:0] event_code_ff;
	logic [LVL_W-1:0] irq_level_ff;
	logic notify_ff;
	logic [DATA_W-1:0] prdata_ff;
	logic nmi_prev_ff;
	logic nmi_flag_ff;
	logic [4:0] blank_cnt_ff;
	logic [LVL_W-1:0] irl_prev_lvl_ff;
	logic setup;
	logic access;
	logic wr_access;
	logic hit;
	logic edge_chg;
	logic nmi_edge;
	logic nmi_set;
	logic nmi_ok;
	logic accepted;
	logic [LVL_W-1:0] irl_lvl;
	logic [LVL_W-1:0] best_lvl;
	logic [CODE_W-1:0] best_code;
	logic [LVL_W-1:0] mask_lvl;
	logic [2*REG_W-1:0] prio_all;
	logic [ST_W-1:0] events;
	logic [REG_W-1:0] ctrl_view;
	logic [DATA_W-1:0] nxt_prdata;

	pin_filter #(.WIDTH(1), .RESET_VAL(1'b0)) nmi_filter (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in(nmi_pin),
		.level_out(nmi_level)
	);

	pin_filter #(.WIDTH(PRIO_W), .RESET_VAL(IRL_IDLE)) irl_filter (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in(encoded_level_inputs),
		.level_out(irl_code)
	);

	// the filters need a few edges before they show the pin; edges are ignored until then
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			startup_ff <= STARTUP_PRIME;
			prime_cnt_ff <= '0;
		end
		else
		begin
			unique case (startup_ff)
				STARTUP_PRIME:
				begin
					prime_cnt_ff <= prime_cnt_ff + 2'h1;
					if (prime_cnt_ff == PRIME_CNT)
						startup_ff <= STARTUP_RUN;
				end
				STARTUP_RUN:
					prime_cnt_ff <= prime_cnt_ff;
			endcase
		end
	end

	assign running = (startup_ff == STARTUP_RUN);

	// apb decode: zero wait states, read data captured in the setup cycle
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign wr_access = access && pwrite;
	assign hit = (paddr == CTRL_ADDR) || (paddr == PRIO_A_ADDR) || (paddr == PRIO_B_ADDR)
		|| (paddr == STATUS_ADDR) || (paddr == MASK_ADDR) || (paddr == EVENT_ADDR);
	assign pready = 1'b1;
	assign pslverr = access && !hit;
	assign prdata = prdata_ff;

	assign ctrl_view = {nmi_level, 6'h00, edge_sel_ff, 8'h00};

	always_comb
	begin
		nxt_prdata = '0;
		unique case (paddr)
			CTRL_ADDR: nxt_prdata = DATA_W'(ctrl_view);
			PRIO_A_ADDR: nxt_prdata = DATA_W'(prio_a_ff);
			PRIO_B_ADDR: nxt_prdata = DATA_W'(prio_b_ff);
			STATUS_ADDR: nxt_prdata = DATA_W'(status_ff);
			MASK_ADDR: nxt_prdata = DATA_W'(mask_ff);
			EVENT_ADDR: nxt_prdata = DATA_W'(event_code_ff);
			default: nxt_prdata = '0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_ff <= '0;
		else if (setup && !pwrite)
			prdata_ff <= nxt_prdata;
	end

	// control and priority registers; both reset kinds arrive on presetn
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			edge_sel_ff <= EDGE_RESET;
			prio_a_ff <= PRIO_RESET;
			prio_b_ff <= PRIO_RESET;
		end
		else if (wr_access)
		begin
			if (paddr == CTRL_ADDR)
				edge_sel_ff <= pwdata[CTRL_EDGE_BIT];
			if (paddr == PRIO_A_ADDR)
				prio_a_ff <= pwdata[REG_W-1:0];
			if (paddr == PRIO_B_ADDR)
				prio_b_ff <= pwdata[REG_W-1:0];
		end
	end

	assign edge_chg = wr_access && (paddr == CTRL_ADDR) && (pwdata[CTRL_EDGE_BIT] != edge_sel_ff);

	// nonmaskable edge detection
	assign nmi_edge = running && (edge_sel_ff ? (nmi_level && !nmi_prev_ff)
		: (!nmi_level && nmi_prev_ff));
	assign nmi_set = nmi_edge && (blank_cnt_ff == '0) && !edge_chg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			nmi_prev_ff <= 1'b0;
		else
			nmi_prev_ff <= nmi_level;
	end

	// blinding window hides edges that a polarity switch would fake
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			blank_cnt_ff <= '0;
		else if (edge_chg)
			blank_cnt_ff <= NMI_BLANK_CNT;
		else if (blank_cnt_ff != '0)
			blank_cnt_ff <= blank_cnt_ff - 5'h01;
	end

	// a fresh edge beats the clear by acceptance
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			nmi_flag_ff <= 1'b0;
		else if (edge_chg)
			nmi_flag_ff <= 1'b0;
		else if (nmi_set)
			nmi_flag_ff <= 1'b1;
		else if (accepted && (best_code == EVT_NMI))
			nmi_flag_ff <= 1'b0;
	end

	// arbitration: strict compare keeps the default order on ties
	assign irl_lvl = {1'b0, IRL_IDLE - irl_code};
	assign prio_all = {prio_b_ff, prio_a_ff};
	assign mask_lvl = {1'b0, cpu_mask_level};
	assign nmi_ok = nmi_flag_ff && (!cpu_block_bit || low_power_mode);

	always_comb
	begin
		best_lvl = irl_lvl;
		best_code = (irl_lvl != '0) ? evt_code(EVT_IRL_BASE, irl_code) : '0;
		for (int i = 0; i < N_PERIPH; i++)
		begin
			if (periph_req[i] && ({1'b0, prio_all[PRIO_W*i +: PRIO_W]} > best_lvl))
			begin
				best_lvl = {1'b0, prio_all[PRIO_W*i +: PRIO_W]};
				best_code = evt_code(EVT_PERIPH_BASE, PRIO_W'(i));
			end
		end
		if (nmi_ok)
		begin
			best_lvl = NMI_LEVEL;
			best_code = EVT_NMI;
		end
	end

	assign cpu_irq_req = nmi_ok || (!cpu_block_bit && (best_lvl > mask_lvl));
	assign accepted = cpu_accept && cpu_irq_req;
	// neither nonmaskable nor encoded-level entry rewrites the cpu mask level
	assign cpu_mask_load = 1'b0;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			event_code_ff <= '0;
		else if (accepted)
			event_code_ff <= best_code;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_level_ff <= '0;
			notify_ff <= 1'b0;
		end
		else
		begin
			irq_level_ff <= best_lvl;
			notify_ff <= nmi_flag_ff || (best_lvl != '0) || refresh_req;
		end
	end

	assign cpu_irq_level = irq_level_ff;
	assign event_code_register = event_code_ff;
	assign pending_notify_out = notify_ff;

	// sticky status, write one to clear, a set in the same cycle wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irl_prev_lvl_ff <= '0;
		else
			irl_prev_lvl_ff <= irl_lvl;
	end

	assign events = {accepted, (irl_lvl != '0) && (irl_prev_lvl_ff == '0), nmi_set};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status_ff <= '0;
		else if (wr_access && (paddr == STATUS_ADDR))
			status_ff <= (status_ff & ~pwdata[ST_W-1:0]) | events;
		else
			status_ff <= status_ff | events;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mask_ff <= '0;
		else if (wr_access && (paddr == MASK_ADDR))
			mask_ff <= pwdata[ST_W-1:0];
	end

	assign irq_out = |(status_ff & mask_ff);

	// encoded sources keep their level until accepted; nothing here latches a lowered one

	AST_LEVEL_ZERO_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
		(cpu_irq_req && !nmi_ok) |-> (best_lvl != '0) && (best_lvl > mask_lvl))
		else $error("request raised for a masked level");

	AST_NMI_UNBLOCKED: assert property (@(posedge pclk) disable iff (!presetn)
		(nmi_flag_ff && !cpu_block_bit) |-> cpu_irq_req && (best_code == EVT_NMI))
		else $error("pending nonmaskable not presented");

	AST_NMI_LOW_POWER: assert property (@(posedge pclk) disable iff (!presetn)
		(nmi_flag_ff && low_power_mode) |-> cpu_irq_req && (best_lvl == NMI_LEVEL))
		else $error("nonmaskable not accepted in low power mode");

	AST_NMI_FROM_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(nmi_flag_ff) |-> $past(nmi_level) != $past(nmi_prev_ff)
			&& $past(nmi_level) == $past(edge_sel_ff))
		else $error("nonmaskable flag set without selected edge");

	AST_EDGE_CHANGE_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
		edge_chg |=> (!nmi_flag_ff) [*8])
		else $error("flag not cleared after polarity change");

	AST_MASK_UNTOUCHED: assert property (@(posedge pclk) disable iff (!presetn)
		(accepted && nmi_ok) |-> ##[0:2] !cpu_mask_load)
		else $error("mask level rewritten by nonmaskable entry");

	AST_LEVEL_BIT_READ: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && !pwrite && (paddr == CTRL_ADDR)) |=> prdata[CTRL_LEVEL_BIT] == $past(nmi_level))
		else $error("control read does not show pin level");

	AST_IRL_DECODE: assert property (@(posedge pclk) disable iff (!presetn)
		(irl_code == IRL_IDLE) |-> (irl_lvl == '0))
		else $error("idle encoding decoded as a request");

	AST_NOTIFY: assert property (@(posedge pclk) disable iff (!presetn)
		(nmi_flag_ff || refresh_req) |=> pending_notify_out)
		else $error("notify output missed a pending cause");

	AST_EVENT_CODE: assert property (@(posedge pclk) disable iff (!presetn)
		(accepted && nmi_ok) |=> (event_code_register == EVT_NMI))
		else $error("wrong event code for nonmaskable");

	AST_BLOCKED: assert property (@(posedge pclk) disable iff (!presetn)
		(cpu_block_bit && !low_power_mode) |-> !cpu_irq_req)
		else $error("request raised while blocked");

	AST_ACCEPT_CODE: assert property (@(posedge pclk) disable iff (!presetn)
		accepted |=> (event_code_register == $past(best_code)))
		else $error("event code differs from accepted cause");

	AST_MASKED_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
		(!nmi_ok && (best_lvl <= mask_lvl)) |-> !cpu_irq_req)
		else $error("request raised at or below the mask level");

	AST_NOTIFY_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
		(!nmi_flag_ff && (best_lvl == '0) && !refresh_req) |=> !pending_notify_out)
		else $error("notify output raised with nothing pending");
endmodule

//--- tb/cpu_core_model.sv
// cpu side model: takes the current request once per go, after lat idle cycles
// assumes cpu_irq_req is a level that holds until the accept pulse is seen
module cpu_core_model
	import priority_arbiter_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cpu_irq_req,
	input wire logic go,
	input wire logic [3:0] lat,
	output logic cpu_accept,
	output logic taken
);
	timeunit 1ns;
	timeprecision 1ps;
	logic accept_ff;
	logic taken_ff;
	logic [3:0] wait_ff;
	assign cpu_accept = accept_ff;
	assign taken = taken_ff;
	// one pulse per go, so a level cause is not taken twice
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			accept_ff <= 1'b0;
			taken_ff <= 1'b0;
			wait_ff <= 4'h0;
		end
		else
		begin
			accept_ff <= 1'b0;
			taken_ff <= go & (taken_ff | accept_ff);
			if (!go || taken_ff || accept_ff || !cpu_irq_req)
				wait_ff <= 4'h0;
			else if (wait_ff == lat)
				accept_ff <= 1'b1;
			else
				wait_ff <= wait_ff + 4'h1;
		end
	end
endmodule

//--- tb/testbench.sv
// self-checking bench for the interrupt priority controller
// assumes a zero-wait apb slave and the cpu model in cpu_core_model
module testbench
	import priority_arbiter_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [3:0] enc;
		logic [7:0] per;
		logic [3:0] msk;
		logic req;
		logic [11:0] code;
	} row_type;
	logic pclk, presetn, psel, penable, pwrite, nmi_pin, refresh_req, cpu_block_bit;
	logic low_power_mode, go, pready, pslverr, cpu_irq_req, cpu_accept, taken, erf;
	logic cpu_mask_load, pending_notify_out, irq_out;
	logic [3:0] lat;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd;
	logic [PRIO_W-1:0] encoded_level_inputs, cpu_mask_level;
	logic [N_PERIPH-1:0] periph_req;
	logic [CODE_W-1:0] event_code_register;
	logic [LVL_W-1:0] cpu_irq_level;
	int err_count, cmp_count;
	// code 0 marks a cause that can never be taken
	row_type rows [12] = '{
		'{4'h0, 8'h00, 4'he, 1'b1, 12'h200}, '{4'h1, 8'h00, 4'he, 1'b0, 12'h220},
		'{4'h1, 8'h00, 4'hd, 1'b1, 12'h220}, '{4'h5, 8'h00, 4'ha, 1'b0, 12'h2a0},
		'{4'h7, 8'h00, 4'h7, 1'b1, 12'h2e0}, '{4'he, 8'h00, 4'h1, 1'b0, 12'h3c0},
		'{4'he, 8'h00, 4'h0, 1'b1, 12'h3c0}, '{4'hf, 8'h01, 4'h0, 1'b0, 12'h000},
		'{4'hf, 8'h02, 4'h4, 1'b1, 12'h420}, '{4'hf, 8'h02, 4'h5, 1'b0, 12'h420},
		'{4'hf, 8'h40, 4'h9, 1'b1, 12'h4c0}, '{4'ha, 8'h02, 4'h0, 1'b1, 12'h340}};

	interrupt_priority_ctrl DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .nmi_pin, .encoded_level_inputs,
		.periph_req, .refresh_req, .cpu_block_bit, .cpu_mask_level, .low_power_mode,
		.cpu_accept, .cpu_irq_req, .cpu_irq_level, .event_code_register,
		.cpu_mask_load, .pending_notify_out, .irq_out);
	cpu_core_model cpu (.pclk, .presetn, .cpu_irq_req, .go, .lat, .cpu_accept, .taken);

	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// one apb transfer; request held until pready is seen at an edge
	task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1 && ++n < 20);
		if (pready !== 1'b1)
		begin
			err_count++;
			print_verdict;
		end
		rd = prdata;
		erf = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task take_irq(input logic [CODE_W-1:0] code);
		int n;
		n = 0;
		go <= 1'b1;
		do
			@(posedge pclk);
		while (taken !== 1'b1 && ++n < 60);
		if (taken !== 1'b1)
		begin
			err_count++;
			print_verdict;
		end
		go <= 1'b0;
		@(posedge pclk);
		chk(event_code_register, code);
		chk(cpu_mask_load, 1'b0);
	endtask

	initial
	begin
		{presetn, psel, penable, pwrite, refresh_req, cpu_block_bit} = 6'h0;
		{low_power_mode, go, lat, paddr, pwdata, periph_req} = '0;
		nmi_pin = 1'b1;
		encoded_level_inputs = 4'hf;
		cpu_mask_level = 4'hf;
		err_count = 0;
		cmp_count = 0;
		tick(4);
		presetn <= 1'b1;
		tick(8);
		chk(cpu_irq_req, 1'b0);
		rdchk(CTRL_ADDR, 32'h8000);
		rdchk(PRIO_A_ADDR, 32'h0);
		rdchk(PRIO_B_ADDR, 32'h0);
		apb(1'b1, PRIO_A_ADDR, 32'h0050);
		apb(1'b1, PRIO_B_ADDR, 32'h0a00);
		rdchk(PRIO_B_ADDR, 32'h0a00);
		apb(1'b0, 12'hff0, 32'h0);
		chk(erf, 1'b1);
		chk(rd, 32'h0);
		nmi_pin <= 1'b0;
		tick(6);
		chk(cpu_irq_req, 1'b1);
		rdchk(CTRL_ADDR, 32'h0);
		chk(cpu_irq_level, NMI_LEVEL);
		take_irq(EVT_NMI);
		chk(cpu_irq_req, 1'b0);
		cpu_block_bit <= 1'b1;
		nmi_pin <= 1'b1;
		tick(6);
		nmi_pin <= 1'b0;
		tick(6);
		chk(cpu_irq_req, 1'b0);
		low_power_mode <= 1'b1;
		tick(2);
		chk(cpu_irq_req, 1'b1);
		take_irq(EVT_NMI);
		low_power_mode <= 1'b0;
		nmi_pin <= 1'b1;
		tick(6);
		nmi_pin <= 1'b0;
		tick(6);
		// pending blocked edge must be wiped by the polarity change
		apb(1'b1, CTRL_ADDR, 32'h0100);
		nmi_pin <= 1'b1;
		tick(10);
		cpu_block_bit <= 1'b0;
		tick(2);
		chk(cpu_irq_req, 1'b0);
		tick(20);
		nmi_pin <= 1'b0;
		tick(6);
		chk(cpu_irq_req, 1'b0);
		nmi_pin <= 1'b1;
		tick(6);
		chk(cpu_irq_req, 1'b1);
		rdchk(CTRL_ADDR, 32'h8100);
		take_irq(EVT_NMI);
		for (int i = 0; i < 12; i++)
		begin
			lat <= 4'(i % 3);
			cpu_mask_level <= rows[i].msk;
			encoded_level_inputs <= rows[i].enc;
			periph_req <= rows[i].per;
			tick(6);
			chk(cpu_irq_req, rows[i].req);
			// mask drops so the level is taken before it is lowered
			cpu_mask_level <= 4'h0;
			tick(1);
			if (rows[i].code != 12'h0)
				take_irq(rows[i].code);
			encoded_level_inputs <= 4'hf;
			periph_req <= 8'h00;
			tick(6);
		end
		encoded_level_inputs <= 4'h0;
		tick(1);
		encoded_level_inputs <= 4'hf;
		// a one-cycle pulse must never reach the arbiter, so watch every cycle
		repeat (8)
		begin
			tick(1);
			chk(cpu_irq_req, 1'b0);
		end
		rdchk(STATUS_ADDR, 32'h7);
		chk(irq_out, 1'b0);
		apb(1'b1, MASK_ADDR, 32'h2);
		chk(irq_out, 1'b1);
		apb(1'b1, STATUS_ADDR, 32'h2);
		chk(irq_out, 1'b0);
		rdchk(STATUS_ADDR, 32'h5);
		chk(pending_notify_out, 1'b0);
		refresh_req <= 1'b1;
		tick(2);
		chk(pending_notify_out, 1'b1);
		refresh_req <= 1'b0;
		nmi_pin <= 1'b0;
		presetn <= 1'b0;
		tick(4);
		presetn <= 1'b1;
		tick(8);
		rdchk(CTRL_ADDR, 32'h0);
		rdchk(PRIO_A_ADDR, 32'h0);
		print_verdict;
	end
endmodule
